// ---- serial_control_port.sv ----
`timescale 1ns/10ps

module serial_control_port
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       sys_rst,
   // Configuration
   input  wire logic       four_wire_select,
   // Serial pins
   input  wire logic       sclk,
   input  wire logic       frame_enable_n,
   input  wire logic       sdio_in,
   output logic            sdio_out,
   output logic            sdio_oe,
   output logic            alarm_data_out,
   output logic            alarm_data_out_oe,
   // Register file side
   output logic [4:0]      reg_addr,
   output logic [7:0]      reg_wdata,
   output logic            reg_write,
   output logic            reg_read,
   input  wire logic [7:0] reg_rdata
);

   // =====================================================================
   // Timing overview
   // =====================================================================
   // Serial clock, frame enable and data pin are asynchronous to clk
   // Each passes a two-flop synchroniser before any logic reads it
   // Edge detect compares the synchronised clock with its last value
   // A pin edge is therefore seen two to three clk cycles late
   // Clock and data share the same delay, so setup is preserved
   // Host serial clock phases must stay above four clk periods
   // Shorter phases let a rise and fall merge inside the pipeline
   // Read bits reach the pin two to three clk cycles after a fall
   // The host samples them on the next rise
   //
   // Frame flow
   //    Frame enable high: bit counter cleared, both drivers off
   //    Frame enable rise: any phase returns to instruction
   //    First eight rises: instruction byte into the shift register
   //    Instruction done: direction, count and start address latched
   //    Write phase: each eighth rise stores one byte
   //    Read phase: each fall puts the next bit on the active pin
   //    Done phase: rises store nothing; the first fall sets the read tail
   //
   // Register side
   //    reg_write is a one-cycle strobe with reg_addr and reg_wdata
   //    reg_read is a one-cycle strobe marking a new reg_addr
   //    reg_rdata must be stable before the following serial fall
   //    The address steps down by one after every write byte and between read bytes
   //    Writes land one byte at a time, never buffered
   //
   // Read data path
   //    Byte loaded from reg_rdata on the first fall of each byte
   //    Remaining seven bits shifted out on the next seven falls
   //    One output bit feeds both pins; the enables pick the pin
   //    Three-wire: shared pin enabled, alarm pin left floating
   //    Four-wire: alarm pin enabled, shared pin left to the host
   //    Four-wire tail: pin held low until the frame closes
   //    Three-wire tail: shared pin released at once
   //
   // Hazards
   //    Mode is latched only while the frame is idle, so a change
   //    of four_wire_select in mid-frame cannot split a read byte
   //    A frame cut short leaves finished bytes written and drops
   //    the partial byte; the next frame starts clean
   //    Bits past the counted bytes are shifted but never stored
   //    A released shared pin is not read as data in the read phase
   //    Reset is synchronous; all enables and strobes clear with it
   //    Synchroniser reset values match the idle pin levels, so no
   //    false serial clock edge or frame start follows reset
   //
   // State fields
   //    sclk_sync, fen_sync, sdi_sync: synchroniser pairs
   //    sclk_prev: last synchronised serial clock level
   //    phase: instruction, write, read or done
   //    bit_cnt: bit position within the current byte
   //    bytes_left: data bytes still to come after this one
   //    shift_in: incoming bits, MSB first
   //    shift_out: outgoing bits still to send
   //    addr: register address of the current data byte
   //    read_dir: direction bit of the instruction
   //    four_wire: mode latched at frame start
   //    out_bit: level on the active output pin
   //    out_en: an output pin is driven
   //    tail_low: read finished, pin parked low in four-wire, released in three-wire
   //    wdata: last received write byte
   //    wr_pulse, rd_pulse: register strobes
   //    Fields not listed keep their value between frames

   // =====================================================================
   // State
   // =====================================================================
   typedef struct packed {
      logic [1:0]                         sclk_sync;
      logic [1:0]                         fen_sync;
      logic [1:0]                         sdi_sync;
      logic                               sclk_prev;
      serial_control_port_pkg::phase_t    phase;
      logic [2:0]                         bit_cnt;
      logic [2:0]                         bytes_left;
      logic [7:0]                         shift_in;
      logic [7:0]                         shift_out;
      logic [4:0]                         addr;
      logic                               read_dir;
      logic                               four_wire;
      logic                               out_bit;
      logic                               out_en;
      logic                               tail_low;
      logic [7:0]                         wdata;
      logic                               wr_pulse;
      logic                               rd_pulse;
   } state_t;

   state_t st_r;
   state_t st_nxt;

   // Next address for multi-byte transfers
   // Wraps from zero to the top address
   function automatic logic [4:0] addr_down(input logic [4:0] a);
      addr_down = a - serial_control_port_pkg::ADDR_STEP;
   endfunction : addr_down

   // =====================================================================
   // Next-state logic
   // =====================================================================
   always_comb
   begin
      logic sclk_s;
      logic fen_s;
      logic sdi_s;
      logic rise;
      logic fall;
      logic [7:0] shifted;
      // Synchronised pin levels and serial clock edges
      sclk_s  = st_r.sclk_sync[1];
      fen_s   = st_r.fen_sync[1];
      sdi_s   = st_r.sdi_sync[1];
      rise    = sclk_s & ~st_r.sclk_prev;
      fall    = ~sclk_s & st_r.sclk_prev;
      shifted = {st_r.shift_in[6:0], sdi_s};
      // Hold everything unless changed below
      st_nxt  = st_r;
      // Two-flop synchronisers for the serial pins
      st_nxt.sclk_sync = {st_r.sclk_sync[0], sclk};
      st_nxt.fen_sync  = {st_r.fen_sync[0], frame_enable_n};
      st_nxt.sdi_sync  = {st_r.sdi_sync[0], sdio_in};
      st_nxt.sclk_prev = sclk_s;
      // Register strobes last one cycle
      st_nxt.wr_pulse  = 1'b0;
      st_nxt.rd_pulse  = 1'b0;
      if (fen_s)
      begin
         // Frame idle: bit counter cleared, outputs released
         st_nxt.phase     = serial_control_port_pkg::PH_INSTR;
         st_nxt.bit_cnt   = serial_control_port_pkg::BIT_RST;
         st_nxt.out_en    = 1'b0;
         st_nxt.tail_low  = 1'b0;
         st_nxt.four_wire = four_wire_select;
      end
      else
      begin
         // Sample input bits on rising edges
         if (rise)
         begin
            st_nxt.shift_in = shifted;
            st_nxt.bit_cnt  = st_r.bit_cnt + serial_control_port_pkg::BIT_STEP;
            if (st_r.bit_cnt == serial_control_port_pkg::BIT_LAST)
            begin
               case (st_r.phase)
                  serial_control_port_pkg::PH_INSTR:
                  begin
                     st_nxt.read_dir   = shifted[serial_control_port_pkg::DIR_BIT];
                     st_nxt.bytes_left = {1'b0,
                        shifted[serial_control_port_pkg::COUNT_HI_BIT:
                                serial_control_port_pkg::COUNT_LO_BIT]};
                     st_nxt.addr = shifted[serial_control_port_pkg::ADDR_HI_BIT:
                                           serial_control_port_pkg::ADDR_LO_BIT];
                     if (shifted[serial_control_port_pkg::DIR_BIT])
                     begin
                        st_nxt.phase    = serial_control_port_pkg::PH_READ;
                        st_nxt.rd_pulse = 1'b1;
                     end
                     else
                        st_nxt.phase = serial_control_port_pkg::PH_WRITE;
                  end
                  serial_control_port_pkg::PH_WRITE:
                  begin
                     // Store byte, stop after the counted bytes
                     st_nxt.wdata    = shifted;
                     st_nxt.wr_pulse = 1'b1;
                     if (st_r.bytes_left == serial_control_port_pkg::BYTE_RST)
                        st_nxt.phase = serial_control_port_pkg::PH_DONE;
                     else
                     begin
                        st_nxt.bytes_left = st_r.bytes_left - serial_control_port_pkg::BYTE_STEP;
                     end
                  end
                  serial_control_port_pkg::PH_READ:
                  begin
                     // Next byte: new address and a read strobe
                     if (st_r.bytes_left == serial_control_port_pkg::BYTE_RST)
                        st_nxt.phase = serial_control_port_pkg::PH_DONE;
                     else
                     begin
                        st_nxt.bytes_left = st_r.bytes_left - serial_control_port_pkg::BYTE_STEP;
                        st_nxt.addr       = addr_down(st_r.addr);
                        st_nxt.rd_pulse   = 1'b1;
                     end
                  end
                  default:
                     st_nxt.phase = serial_control_port_pkg::PH_DONE;
               endcase
            end
         end
         // Advance write address after each stored byte
         if (st_r.wr_pulse)
            st_nxt.addr = addr_down(st_r.addr);
         // Drive read bits on falling edges
         if (fall)
         begin
            if (st_r.phase == serial_control_port_pkg::PH_READ)
            begin
               st_nxt.out_en = 1'b1;
               // First bit of a byte from the register, later ones shifted
               if (st_r.bit_cnt == serial_control_port_pkg::BIT_RST)
               begin
                  st_nxt.out_bit   = reg_rdata[7];
                  st_nxt.shift_out = {reg_rdata[6:0], 1'b0};
               end
               else
               begin
                  st_nxt.out_bit   = st_r.shift_out[7];
                  st_nxt.shift_out = {st_r.shift_out[6:0], 1'b0};
               end
            end
            // Tail low once, then hold or release
            else if (st_r.phase == serial_control_port_pkg::PH_DONE && st_r.out_en
                     && !st_r.tail_low)
            begin
               st_nxt.out_bit  = 1'b0;
               st_nxt.tail_low = 1'b1;
               st_nxt.out_en   = st_r.four_wire;
            end
         end
      end
   end

   // =====================================================================
   // Registered state
   // =====================================================================
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         st_r            <= '0;
         st_r.sclk_sync  <= 2'h0;
         st_r.fen_sync   <= 2'h3;
         st_r.phase      <= serial_control_port_pkg::PH_INSTR;
         st_r.shift_in   <= serial_control_port_pkg::SHIFT_RST;
         st_r.addr       <= serial_control_port_pkg::ADDR_RST;
      end
      else
         st_r <= st_nxt;
   end

   // =====================================================================
   // Pin and register-side outputs
   // =====================================================================
   // Read bit to both pins, enable selects one
   assign sdio_out          = st_r.out_bit;
   assign sdio_oe           = st_r.out_en & ~st_r.four_wire;
   assign alarm_data_out    = st_r.out_bit;
   assign alarm_data_out_oe = st_r.out_en & st_r.four_wire;

   // Register file side
   assign reg_addr          = st_r.addr;
   assign reg_wdata         = st_r.wdata;
   assign reg_write         = st_r.wr_pulse;
   assign reg_read          = st_r.rd_pulse;

endmodule : serial_control_port

// ---- serial_control_port_pkg.sv ----
package serial_control_port_pkg;

   // =====================================================================
   // Instruction byte layout
   // =====================================================================
   localparam int DIR_BIT        = 7;
   localparam int COUNT_HI_BIT   = 6;
   localparam int COUNT_LO_BIT   = 5;
   localparam int ADDR_HI_BIT    = 4;
   localparam int ADDR_LO_BIT    = 0;
   localparam int BYTE_BITS      = 8;
   localparam int ADDR_BITS      = 5;
   localparam int BYTE_CNT_BITS  = 3;

   // =====================================================================
   // Counts and reset values
   // =====================================================================
   localparam logic [2:0] BIT_LAST      = 3'h7;
   localparam logic [2:0] BIT_RST       = 3'h0;
   localparam logic [2:0] BYTE_RST      = 3'h0;
   localparam logic [7:0] SHIFT_RST     = 8'h00;
   localparam logic [4:0] ADDR_RST      = 5'h00;
   localparam logic [4:0] ADDR_STEP     = 5'h01;
   localparam logic [2:0] BYTE_STEP     = 3'h1;
   localparam logic [2:0] BIT_STEP      = 3'h1;

   // =====================================================================
   // Frame phases
   // =====================================================================
   typedef enum logic [1:0] {
      PH_INSTR,
      PH_WRITE,
      PH_READ,
      PH_DONE
   } phase_t;

endpackage : serial_control_port_pkg

// ---- serial_control_port_asserts.sv ----
`timescale 1ns/10ps
module serial_control_port_asserts
(
   // Clock, reset and mode
   input wire logic       clk,
   input wire logic       sys_rst,
   input wire logic       four_wire_select,
   // Serial pins
   input wire logic       sclk,
   input wire logic       frame_enable_n,
   input wire logic       sdio_in,
   input wire logic       sdio_out,
   input wire logic       sdio_oe,
   input wire logic       alarm_data_out,
   input wire logic       alarm_data_out_oe,
   // Register file side
   input wire logic [4:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_write,
   input wire logic       reg_read,
   input wire logic [7:0] reg_rdata
);
   // ==================================================================
   // Ages of the last serial clock edges
   // ==================================================================
   logic       sclk_q_r;
   logic [3:0] rise_age_r;
   logic [3:0] fall_age_r;
   logic [4:0] wr_addr_r;
   // Saturating counters, restarted at each seen edge
   always_ff @(posedge clk)
   begin
      sclk_q_r   <= sclk;
      rise_age_r <= (sclk && !sclk_q_r) ? 4'h0 : rise_age_r + {3'h0, rise_age_r != 4'hF};
      fall_age_r <= (!sclk && sclk_q_r) ? 4'h0 : fall_age_r + {3'h0, fall_age_r != 4'hF};
      if (reg_write)
         wr_addr_r <= reg_addr;
   end
   // ==================================================================
   // Properties
   // ==================================================================
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence s_fall_recent;
      fall_age_r < 4'h8;
   endsequence
   sequence s_out_moved;
      ($changed(alarm_data_out) && alarm_data_out_oe && $past(alarm_data_out_oe))
      || ($changed(sdio_out) && sdio_oe && $past(sdio_oe));
   endsequence
   a_modes_exclusive: assert property (!(sdio_oe && alarm_data_out_oe))
      else $error("both data outputs enabled");
   a_shared_three_wire: assert property (sdio_oe |-> !four_wire_select)
      else $error("shared pin driven in four-wire mode");
   a_alarm_four_only: assert property (alarm_data_out_oe |-> four_wire_select)
      else $error("alarm pin driven in three-wire mode");
   a_sample_on_rise: assert property ((reg_write || reg_read) |-> rise_age_r < 4'h8)
      else $error("register strobe without recent clock rise");
   a_out_on_fall: assert property (s_out_moved |-> s_fall_recent)
      else $error("read bit moved away from a clock fall");
   a_strobe_in_frame: assert property ((reg_write || reg_read) |-> !$past(frame_enable_n, 4))
      else $error("register strobe outside a frame");
   a_dir_exclusive: assert property (!(reg_write && reg_read))
      else $error("read and write strobes together");
   a_addr_decrement: assert property (reg_write |=> ##[0:1] reg_addr == wr_addr_r - 5'h01)
      else $error("address did not step down after write");
   a_idle_release: assert property (frame_enable_n [*6] |-> !sdio_oe && !alarm_data_out_oe)
      else $error("output still enabled after frame end");
endmodule : serial_control_port_asserts

bind serial_control_port serial_control_port_asserts serial_control_port_asserts_inst
(
   .clk(clk), .sys_rst(sys_rst), .four_wire_select(four_wire_select), .sclk(sclk),
   .frame_enable_n(frame_enable_n), .sdio_in(sdio_in), .sdio_out(sdio_out),
   .sdio_oe(sdio_oe), .alarm_data_out(alarm_data_out), .alarm_data_out_oe(alarm_data_out_oe),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
   .reg_read(reg_read), .reg_rdata(reg_rdata)
);

// ---- serial_host.sv ----
`timescale 1ns/10ps
module serial_host
#(
   parameter int HALF = 50
)
(
   // Serial pins driven by the host
   output logic           sclk,
   output logic           frame_enable_n,
   output logic           host_d,
   output logic           host_oe,
   // Line levels seen by the host
   input  wire logic      d_line,
   input  wire logic      alarm_line,
   input  wire logic      four_wire
);
   logic tail;
   // Idle: clock parked low, frame closed
   initial
   begin
      sclk = 0;
      frame_enable_n = 1;
      host_d = 0;
      host_oe = 1;
   end
   // One frame: instruction then nb data bytes, read bits taken on rises
   task automatic xfer(input logic [7:0] ins, input int nb, input logic [31:0] wd,
                       output logic [31:0] rd);
      logic [39:0] s;
      s = {ins, wd};
      rd = '0;
      frame_enable_n = 0;
      #HALF;
      for (int i = 0; i < 8 * nb + 8; i++)
      begin
         sclk = 0;
         host_oe = !(ins[7] && i >= 8);
         host_d = s[39 - i];
         #HALF;
         sclk = 1;
         if (i >= 8)
            rd[39 - i] = four_wire ? alarm_line : d_line;
         #HALF;
      end
      sclk = 0;
      #HALF;
      tail = alarm_line;
      frame_enable_n = 1;
      host_oe = 1;
      #HALF;
   endtask : xfer
endmodule : serial_host

// ---- serial_control_port_bench.sv ----
`timescale 1ns/10ps
module serial_control_port_bench;
   // Pins, register file and reference model
   logic        sys_rst, four_wire_select, sdio_in, sclk, frame_enable_n;
   logic        clk = 1'b0;
   logic        tgl = 1'b0;
   logic        host_d, host_oe, alarm_line, sdio_out, sdio_oe, alarm_data_out;
   logic        alarm_data_out_oe, reg_write, reg_read;
   logic [4:0]  reg_addr;
   logic [7:0]  reg_wdata;
   logic [7:0]  reg_rdata;
   logic [7:0]  mem [32];
   logic [31:0] rd;
   int          ref_m [32];
   int          exp_w [$];
   int          exp_r [$];
   int          n_errors, n_checks, cyc, n, nb, a, wd;
   serial_control_port serial_control_port_inst
   (
      .clk(clk), .sys_rst(sys_rst), .four_wire_select(four_wire_select), .sclk(sclk),
      .frame_enable_n(frame_enable_n), .sdio_in(sdio_in), .sdio_out(sdio_out),
      .sdio_oe(sdio_oe), .alarm_data_out(alarm_data_out), .alarm_data_out_oe(alarm_data_out_oe),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata)
   );
   serial_host #(.HALF(24)) serial_host_inst
   (
      .sclk(sclk), .frame_enable_n(frame_enable_n), .host_d(host_d), .host_oe(host_oe),
      .d_line(sdio_in), .alarm_line(alarm_line), .four_wire(four_wire_select)
   );
   // Line levels; a released line toggles instead of holding
   assign sdio_in    = sdio_oe ? sdio_out : (host_oe ? host_d : tgl);
   assign alarm_line = alarm_data_out_oe ? alarm_data_out : tgl;
   assign reg_rdata  = mem[reg_addr];
   always #2.5 clk = !clk;
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task tally_and_finish();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : tally_and_finish
   // Register file, strobe monitor and hang guard
   always @(posedge clk)
   begin
      tgl <= !tgl;
      cyc <= cyc + 1;
      if (reg_write === 1'b1)
      begin
         mem[reg_addr] <= reg_wdata;
         chk({3'h0, reg_addr, reg_wdata}, 16'(exp_w.pop_front()));
      end
      if (reg_read === 1'b1)
         chk({11'h000, reg_addr}, 16'(exp_r.pop_front()));
      if (cyc == 40000)
      begin
         n_errors++;
         tally_and_finish();
      end
   end
   // Write then read back, every count in both modes, overrun and abort
   initial
   begin
      n_errors = 0;
      n_checks = 0;
      sys_rst = 1;
      four_wire_select = 0;
      void'($urandom(68));
      for (int i = 0; i < 32; i++)
      begin
         mem[i] = 8'($urandom);
         ref_m[i] = mem[i];
      end
      repeat (2) @(posedge clk);
      for (int t = 0; t < 10; t++)
      begin
         @(negedge clk);
         sys_rst = (t == 4);
         four_wire_select = t[2];
         @(negedge clk);
         sys_rst = 0;
         repeat (4) @(negedge clk);
         n = t % 4 + 1;
         nb = (t == 8) ? 2 : (t == 9) ? 1 : n;
         a = $urandom % 32;
         wd = $urandom;
         for (int k = 0; k < n && k < nb; k++)
         begin
            ref_m[(a - k) & 31] = (wd >> (24 - 8 * k)) & 255;
            exp_w.push_back(((a - k) & 31) * 256 + ref_m[(a - k) & 31]);
         end
         serial_host_inst.xfer({1'b0, 2'(n - 1), 5'(a)}, nb, wd, rd);
         for (int k = 0; k < n; k++)
            exp_r.push_back((a - k) & 31);
         serial_host_inst.xfer({1'b1, 2'(n - 1), 5'(a)}, n, 0, rd);
         for (int k = 0; k < n; k++)
            chk({8'h00, rd[31 - 8 * k -: 8]}, 16'(ref_m[(a - k) & 31]));
         if (four_wire_select)
            chk({15'h0000, serial_host_inst.tail}, 16'h0000);
         $display("test %0d done", t);
      end
      repeat (10) @(negedge clk);
      chk(16'(exp_w.size() + exp_r.size()), 16'h0000);
      tally_and_finish();
   end
endmodule : serial_control_port_bench
